//--- core/sck_top.sv
/*
 * Synchro-check: voltage, frequency, phase and rotation checks, qualify
 * timer, one-second withdraw hold and breaker close gating.
 * Assumes measurement inputs arrive from other clock domains with a sample
 * strobe that is a level toggle; all are resynchronised here.
 */
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`include "sck_regs.svh"

// Functional notes
// - No sequence starts while either breaker side lacks voltage.
// - With internal regulation or forcing, close waits for sync status.
// - External regulation without forcing closes at once.
// - Forcing ignored with internal regulation; separate per breaker.
// - Forcing defaults to both breakers after reset.
// - Forced check that cannot run raises incoherent setting warning.
// - Six checks; close only when every applicable one passes.
// - Every voltage within its min/max percent limits, else blocked.
// - Per-phase difference against max with 1% hysteresis, voltages first.
// - Single phase compares only the first phase.
// - Voltages handled as percent of their own nominal.
// - Both frequencies within percent limits of nominal, else blocked.
// - Frequency difference against max with 0.1 Hz hysteresis.
// - Phase difference below max degrees with 1 degree hysteresis.
// - Signed offset up to +/-180 degrees applied to phase.
// - Three-phase only: identical rotation on both sides required.
// - Sync after all checks pass through qualify time; failure restarts.
// - Withdrawn consent stays withdrawn at least one second.
// - Close only after unsynchronized then synchronized is observed.
// - Internal regulation forces an unsynchronized state first.
// - Separate pass indications for each check group and close enable.
module sck_top
    import sck_pkg::*;
#(
    parameter int HOLD_CYC = `SCK_HOLD_CYC,
    parameter int MS_CYC = `SCK_QUAL_MS_CYC
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Avalon-MM slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Measurement front end (percent, 0.1 Hz, degrees)
    input wire logic SAMPLE_TGL,
    input wire logic [23:0] MAINS_VOLT_PCT,
    input wire logic [23:0] GEN_VOLT_PCT,
    input wire logic [15:0] MAINS_FREQ,
    input wire logic [15:0] GEN_FREQ,
    input wire logic [8:0] PHASE_DEG,
    input wire logic MAINS_ROT_CW,
    input wire logic GEN_ROT_CW,
    // Breaker and status
    output logic BREAKER_CLOSE,
    output logic VOLT_OK,
    output logic FREQ_OK,
    output logic PHASE_OK,
    output logic ROT_OK,
    output logic CLOSE_ENABLE,
    output logic INCOHERENT_SETTING_WARNING
);

////////////////////////////////////////////////////////////////////////////
// Registers
logic [31:0] ctrl_q, vlim_q, flim_q, diff_q, qual_q;
logic ack_q, wait_q;
logic [31:0] rdata_q;
logic [2:0] smp_s1_q;
logic smp_s2_q;
logic smp_seen_q;
logic [23:0] mv_s1_q, mv_q, gv_s1_q, gv_q;
logic [15:0] mf_s1_q, mf_q, gf_s1_q, gf_q;
logic [8:0] ph_s1_q, ph_q;
logic [1:0] rot_s1_q, rot_q;
logic v_ok_q, f_ok_q, p_ok_q, r_ok_q;
logic vd_ok_q, fd_ok_q;
logic [31:0] qual_cnt_q, hold_cnt_q;
sck_state_e st_q;
logic en_q, close_q, warn_q;
logic volt_ok_q, freq_ok_q;

wire intreg = ctrl_q[`SCK_CTRL_INTREG];
wire sel_gb = ctrl_q[`SCK_CTRL_SEL_GB];
wire three_ph = ctrl_q[`SCK_CTRL_THREE_PH];
wire force_sel = sel_gb ? ctrl_q[`SCK_CTRL_FORCE_GB]
                        : ctrl_q[`SCK_CTRL_FORCE_MB];
// Forcing is meaningless when regulation is ours
wire check_on = intreg | force_sel;

////////////////////////////////////////////////////////////////////////////
// Avalon slave: one wait cycle, then answer
wire req = (AVS_READ | AVS_WRITE) & ~ack_q;
always_ff @(posedge CLK)
begin
    if (SRST)
    begin
        ack_q <= 1'b0;
        wait_q <= 1'b1;
    end
    else
    begin
        ack_q <= req;
        // Kept beside ack_q so the pin leaves a flip-flop directly
        wait_q <= ~req;
    end
end

// Writes take effect on the answer edge
always_ff @(posedge CLK)
begin
    if (SRST)
    begin
        ctrl_q <= `SCK_CTRL_RST;
        vlim_q <= `SCK_VLIM_RST;
        flim_q <= `SCK_FLIM_RST;
        diff_q <= `SCK_DIFF_RST;
        qual_q <= `SCK_QUAL_RST;
    end
    else if (AVS_WRITE & ack_q)
    begin
        if (AVS_ADDRESS == `SCK_CTRL_OFS)
            ctrl_q <= {25'h0, AVS_WRITEDATA[6:0]};
        else if (AVS_ADDRESS == `SCK_VLIM_OFS)
            vlim_q <= {8'h0, AVS_WRITEDATA[23:0]};
        else if (AVS_ADDRESS == `SCK_FLIM_OFS)
            flim_q <= {16'h0, AVS_WRITEDATA[15:0]};
        else if (AVS_ADDRESS == `SCK_DIFF_OFS)
            diff_q <= {7'h0, AVS_WRITEDATA[24:0]};
        else if (AVS_ADDRESS == `SCK_QUAL_OFS)
            qual_q <= {16'h0, AVS_WRITEDATA[15:0]};
    end
end

// Read mux; unmapped reads return zero
always_ff @(posedge CLK)
begin
    if (SRST)
        rdata_q <= 32'h0;
    else if (AVS_READ & req)
    begin
        if (AVS_ADDRESS == `SCK_CTRL_OFS)
            rdata_q <= ctrl_q;
        else if (AVS_ADDRESS == `SCK_VLIM_OFS)
            rdata_q <= vlim_q;
        else if (AVS_ADDRESS == `SCK_FLIM_OFS)
            rdata_q <= flim_q;
        else if (AVS_ADDRESS == `SCK_DIFF_OFS)
            rdata_q <= diff_q;
        else if (AVS_ADDRESS == `SCK_QUAL_OFS)
            rdata_q <= qual_q;
        else if (AVS_ADDRESS == `SCK_MVOLT_OFS)
            rdata_q <= {8'h0, mv_q};
        else if (AVS_ADDRESS == `SCK_GVOLT_OFS)
            rdata_q <= {8'h0, gv_q};
        else if (AVS_ADDRESS == `SCK_FREQ_OFS)
            rdata_q <= {mf_q, gf_q};
        else if (AVS_ADDRESS == `SCK_PHASE_OFS)
            rdata_q <= {23'h0, ph_q};
        else if (AVS_ADDRESS == `SCK_STAT_OFS)
            rdata_q <= {24'h0, warn_q, close_q, en_q, r_ok_q,
                        p_ok_q, f_ok_q & fd_ok_q, v_ok_q & vd_ok_q,
                        st_q == SCK_SYNC};
        else
            rdata_q <= 32'h0;
    end
end
assign AVS_READDATA = rdata_q;
assign AVS_WAITREQUEST = wait_q;

////////////////////////////////////////////////////////////////////////////
// Front-end synchronisers; the strobe toggles once values are stable.
// No reset: the chain keeps the pin's level, so leaving reset is never
// taken for a toggle. Reset must last four edges at power-up.
always_ff @(posedge CLK)
begin
    smp_s1_q <= {smp_s1_q[1:0], SAMPLE_TGL};
    smp_s2_q <= smp_s1_q[2];
end
// Bus words pass two stages, one fewer than the strobe, so they settle before it is seen
always_ff @(posedge CLK)
begin
    mv_s1_q <= MAINS_VOLT_PCT;
    gv_s1_q <= GEN_VOLT_PCT;
    mf_s1_q <= MAINS_FREQ;
    gf_s1_q <= GEN_FREQ;
    ph_s1_q <= PHASE_DEG;
    rot_s1_q <= {MAINS_ROT_CW, GEN_ROT_CW};
    mv_q <= mv_s1_q;
    gv_q <= gv_s1_q;
    mf_q <= mf_s1_q;
    gf_q <= gf_s1_q;
    ph_q <= ph_s1_q;
    rot_q <= rot_s1_q;
end
wire smp = smp_s2_q ^ smp_s1_q[2];

always_ff @(posedge CLK)
begin
    if (SRST)
        smp_seen_q <= 1'b0;
    else if (smp)
        smp_seen_q <= 1'b1;
end

////////////////////////////////////////////////////////////////////////////
// Check arithmetic; values already percent of own nominal
logic [2:0] v_in, vd_pass, vd_fail;
genvar gi;
generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ph
        wire [7:0] m = mv_q[8*gi +: 8];
        wire [7:0] g = gv_q[8*gi +: 8];
        wire [7:0] d = (m > g) ? m - g : g - m;
        wire used = three_ph | (gi == 0);
        assign v_in[gi] = ~used |
            (m >= vlim_q[7:0] && m <= vlim_q[15:8] &&
             g >= vlim_q[7:0] && g <= vlim_q[15:8]);
        assign vd_pass[gi] = ~used |
            (9'(d) + 9'(`SCK_HYST_V) <= 9'(diff_q[7:0]));
        assign vd_fail[gi] = used & (d > diff_q[7:0]);
    end
endgenerate

wire [15:0] fmin = {8'h0, flim_q[7:0]};
wire [15:0] fmax = {8'h0, flim_q[15:8]};
// Frequencies in 0.1 Hz; nominal limits in percent of 50.0 Hz
wire [15:0] mfp = 16'((32'(mf_q) * 32'd2) / 32'd10);
wire [15:0] gfp = 16'((32'(gf_q) * 32'd2) / 32'd10);
wire f_in = mfp >= fmin && mfp <= fmax && gfp >= fmin && gfp <= fmax;
wire [15:0] fd = (mf_q > gf_q) ? mf_q - gf_q : gf_q - mf_q;
wire [15:0] fdmax = {8'h0, diff_q[15:8]};

// Signed phase, offset applied, wrapped to +/-180
// Offset is the measured angle that counts as in phase
wire signed [9:0] ph_off = 10'($signed(diff_q[24:16]));
wire signed [10:0] ph_raw = 11'($signed({1'b0, ph_q})) - 11'(ph_off);
wire signed [10:0] ph_w = (ph_raw > 11'sd180) ? ph_raw - 11'sd360 :
                          (ph_raw < -11'sd180) ? ph_raw + 11'sd360 :
                          ph_raw;
wire [10:0] ph_abs = ph_w[10] ? 11'(-ph_w) : 11'(ph_w);
wire [10:0] pmax = {3'h0, vlim_q[23:16] == 8'h0 ? 8'd10 : vlim_q[23:16]};

////////////////////////////////////////////////////////////////////////////
// Check results with hysteresis, updated per sample set
always_ff @(posedge CLK)
begin
    if (SRST)
    begin
        v_ok_q <= 1'b0;
        vd_ok_q <= 1'b0;
        f_ok_q <= 1'b0;
        fd_ok_q <= 1'b0;
        p_ok_q <= 1'b0;
        r_ok_q <= 1'b0;
    end
    else if (smp)
    begin
        v_ok_q <= &v_in;
        // Difference only judged once voltages sit in tolerance
        if (!(&v_in))
            vd_ok_q <= 1'b0;
        else if (&vd_pass)
            vd_ok_q <= 1'b1;
        else if (|vd_fail)
            vd_ok_q <= 1'b0;
        f_ok_q <= f_in;
        if (!f_in)
            fd_ok_q <= 1'b0;
        else if (fd + 16'(`SCK_HYST_F) <= fdmax)
            fd_ok_q <= 1'b1;
        else if (fd > fdmax)
            fd_ok_q <= 1'b0;
        if (ph_abs + 11'(`SCK_HYST_P) <= pmax)
            p_ok_q <= 1'b1;
        else if (ph_abs > pmax)
            p_ok_q <= 1'b0;
        r_ok_q <= ~three_ph | (rot_q[1] == rot_q[0]);
    end
end

wire all_ok = v_ok_q & vd_ok_q & f_ok_q & fd_ok_q & p_ok_q & r_ok_q;
wire live = v_ok_q;

////////////////////////////////////////////////////////////////////////////
// Qualify timer: restarts on any failing check
wire [31:0] qual_lim = 32'(qual_q[15:0]) * 32'(MS_CYC);
always_ff @(posedge CLK)
begin
    if (SRST || !all_ok || st_q != SCK_UNSYNC)
        qual_cnt_q <= 32'h0;
    else if (qual_cnt_q < qual_lim)
        qual_cnt_q <= qual_cnt_q + 32'h1;
end

// Sequence: only unsync -> sync grants; withdraw holds one second
always_ff @(posedge CLK)
begin
    if (SRST)
    begin
        st_q <= SCK_IDLE;
        hold_cnt_q <= 32'h0;
    end
    else
    begin
        case (st_q)
            SCK_IDLE:
                // Start disabled: without internal regulation a pass at entry must first fail
                if (ctrl_q[`SCK_CTRL_CLOSE_REQ] & live & smp_seen_q
                    & ~all_ok)
                    st_q <= SCK_UNSYNC;
                else if (ctrl_q[`SCK_CTRL_CLOSE_REQ] & live & intreg)
                    st_q <= SCK_UNSYNC;
            SCK_UNSYNC:
                if (!ctrl_q[`SCK_CTRL_CLOSE_REQ] || !live)
                    st_q <= SCK_IDLE;
                else if (all_ok && qual_cnt_q >= qual_lim)
                    st_q <= SCK_SYNC;
            SCK_SYNC:
                if (!all_ok || !ctrl_q[`SCK_CTRL_CLOSE_REQ])
                begin
                    st_q <= SCK_HOLD;
                    hold_cnt_q <= 32'h0;
                end
            default:
                if (hold_cnt_q >= 32'(HOLD_CYC - 1))
                    st_q <= SCK_IDLE;
                else
                    hold_cnt_q <= hold_cnt_q + 32'h1;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Outputs, all registered
always_ff @(posedge CLK)
begin
    if (SRST)
    begin
        en_q <= 1'b0;
        close_q <= 1'b0;
        warn_q <= 1'b0;
        volt_ok_q <= 1'b0;
        freq_ok_q <= 1'b0;
    end
    else
    begin
        en_q <= st_q == SCK_SYNC;
        // Without internal checking the external device gates the close
        close_q <= ctrl_q[`SCK_CTRL_CLOSE_REQ] &
                   (check_on ? (st_q == SCK_SYNC) : 1'b1);
        warn_q <= ~intreg & force_sel &
                  ~ctrl_q[`SCK_CTRL_CAN_CHK];
        volt_ok_q <= v_ok_q & vd_ok_q;
        freq_ok_q <= f_ok_q & fd_ok_q;
    end
end
assign BREAKER_CLOSE = close_q;
assign CLOSE_ENABLE = en_q;
assign VOLT_OK = volt_ok_q;
assign FREQ_OK = freq_ok_q;
assign PHASE_OK = p_ok_q;
assign ROT_OK = r_ok_q;
assign INCOHERENT_SETTING_WARNING = warn_q;

////////////////////////////////////////////////////////////////////////////
// Checks
sync_needs_pass_a: assert property (@(posedge CLK) disable iff (SRST)
    st_q == SCK_UNSYNC && $past(st_q) == SCK_UNSYNC ##1 st_q == SCK_SYNC
    |-> $past(all_ok)) else $error("sync without pass");
hold_keeps_off_a: assert property (@(posedge CLK) disable iff (SRST)
    $fell(en_q) |-> !en_q [*8]) else $error("consent regained");
close_gated_a: assert property (@(posedge CLK) disable iff (SRST)
    $rose(close_q) && $past(check_on) |-> $past(st_q) == SCK_SYNC)
    else $error("close before sync");
close_direct_a: assert property (@(posedge CLK) disable iff (SRST)
    ctrl_q[`SCK_CTRL_CLOSE_REQ] && !check_on |=> close_q)
    else $error("direct close late");
start_live_a: assert property (@(posedge CLK) disable iff (SRST)
    st_q == SCK_IDLE && !live |=> st_q != SCK_UNSYNC)
    else $error("start while dead");
enable_after_unsync_a: assert property (@(posedge CLK) disable iff (SRST)
    $rose(st_q == SCK_SYNC) |-> $past(st_q) == SCK_UNSYNC)
    else $error("sync not from unsync");
warn_cause_a: assert property (@(posedge CLK) disable iff (SRST)
    warn_q |-> $past(force_sel) && !$past(intreg))
    else $error("spurious warning");
volt_block_a: assert property (@(posedge CLK) disable iff (SRST)
    !v_ok_q |-> !vd_ok_q) else $error("diff ok with bad volts");
cov_sync_c: cover property (@(posedge CLK) $rose(en_q));
cov_hold_c: cover property (@(posedge CLK) $fell(en_q));
cov_warn_c: cover property (@(posedge CLK) $rose(warn_q));

endmodule

//--- core/sck_regs.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * synchro-check block. Assumes a 100 MHz system clock.
 */
`ifndef SCK_REGS_SVH
`define SCK_REGS_SVH

// Word offsets (byte addresses on the Avalon slave)
`define SCK_CTRL_OFS 8'h00
`define SCK_VLIM_OFS 8'h04
`define SCK_FLIM_OFS 8'h08
`define SCK_DIFF_OFS 8'h0c
`define SCK_QUAL_OFS 8'h10
`define SCK_MVOLT_OFS 8'h14
`define SCK_GVOLT_OFS 8'h18
`define SCK_FREQ_OFS 8'h1c
`define SCK_PHASE_OFS 8'h20
`define SCK_STAT_OFS 8'h24

// Control fields
`define SCK_CTRL_INTREG 0
`define SCK_CTRL_FORCE_MB 1
`define SCK_CTRL_FORCE_GB 2
`define SCK_CTRL_CAN_CHK 3
`define SCK_CTRL_THREE_PH 4
`define SCK_CTRL_CLOSE_REQ 5
`define SCK_CTRL_SEL_GB 6
`define SCK_CTRL_RST 32'h0000_001e

// Threshold reset values (percent, 0.1 Hz, degrees)
`define SCK_VLIM_RST 32'h0000_6e50
`define SCK_FLIM_RST 32'h0000_6e5a
`define SCK_DIFF_RST 32'h000a_0305
`define SCK_QUAL_RST 32'h0000_0032

// Fixed hysteresis: 1 %, 0.1 Hz (one unit), 1 degree
`define SCK_HYST_V 8'h01
`define SCK_HYST_F 8'h01
`define SCK_HYST_P 8'h01

// Timing
`define SCK_CLK_MHZ 100
`define SCK_HOLD_MS 1000
`define SCK_HOLD_CYC (`SCK_HOLD_MS * 1000 * `SCK_CLK_MHZ)
`define SCK_QUAL_MS_CYC (1000 * `SCK_CLK_MHZ)

`endif

//--- core/sck_pkg.sv
/*
 * Types of the synchro-check block.
 * Assumes sck_regs.svh supplies the numeric constants.
 */
package sck_pkg;
    typedef enum logic [3:0] {
        SCK_IDLE = 4'b0001,
        SCK_UNSYNC = 4'b0010,
        SCK_SYNC = 4'b0100,
        SCK_HOLD = 4'b1000
    } sck_state_e;
    typedef logic [7:0] sck_pct_t;
endpackage

//--- verif/sck_front.sv
/*
 * Measurement front end model: drives one set of percent voltages,
 * frequencies, phase and rotation, then toggles the sample strobe.
 * Assumes the clock of the block and a bench that calls send.
 */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
module sck_front
(
    // Clock
    input wire logic clk,
    // Measurement set
    output logic tgl,
    output logic [23:0] mv,
    output logic [23:0] gv,
    output logic [15:0] mf,
    output logic [15:0] gf,
    output logic [8:0] ph,
    output logic mr,
    output logic gr
);
    // Dead lines at power up, as an idle front end shows
    initial
    begin
        tgl = 1'b0;
        mv = 24'h0;
        gv = 24'h0;
        mf = 16'h0;
        gf = 16'h0;
        ph = 9'h0;
        mr = 1'b1;
        gr = 1'b0;
    end

    // Data settle 3 edges before and 8 after the toggle, so the block
    // never sees a half-updated set
    task automatic send(input logic [23:0] a, input logic [23:0] b,
        input logic [15:0] c, input logic [15:0] d, input logic [8:0] e,
        input logic f, input logic g);
        @(posedge clk);
        mv <= a;
        gv <= b;
        mf <= c;
        gf <= d;
        ph <= e;
        mr <= f;
        gr <= g;
        repeat (3) @(posedge clk);
        tgl <= ~tgl;
        repeat (8) @(posedge clk);
    endtask
endmodule

//--- verif/test_synchro_check.sv
/*
 * Self-checking bench of the synchro-check block: registers, limits,
 * hysteresis, qualify and hold timing, close routing.
 * Assumes sck_top and the front end model sck_front.
 */
`timescale 1ns/1ns
`include "sck_regs.svh"
////////////////////////////////////////////////////////////////////////
module test_synchro_check;
    // Status bit positions
    localparam int BRK = 0;
    localparam int VO = 1;
    localparam int FR = 2;
    localparam int PH = 3;
    localparam int CE = 5;
    localparam int WN = 6;
    // Good set: 100 % on all phases, 50.0 Hz
    localparam logic [23:0] VG = 24'h646464;
    localparam logic [15:0] FG = 16'h01f4;
    logic clk;
    logic srst;
    logic [7:0] adr;
    logic rd_en;
    logic wr_en;
    logic [31:0] wdat;
    wire logic [31:0] rdat;
    wire logic wait_r;
    wire logic tgl;
    wire logic [23:0] mv;
    wire logic [23:0] gv;
    wire logic [15:0] mf;
    wire logic [15:0] gf;
    wire logic [8:0] ph;
    wire logic mr;
    wire logic gr;
    wire logic [6:0] st;
    int n_fail;
    int n_compared;

    // Short hold and qualify units keep the run brief
    sck_top #(.HOLD_CYC(50), .MS_CYC(2)) dut (.CLK(clk), .SRST(srst),
        .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
        .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_r), .SAMPLE_TGL(tgl), .MAINS_VOLT_PCT(mv),
        .GEN_VOLT_PCT(gv), .MAINS_FREQ(mf), .GEN_FREQ(gf), .PHASE_DEG(ph),
        .MAINS_ROT_CW(mr), .GEN_ROT_CW(gr), .BREAKER_CLOSE(st[0]),
        .VOLT_OK(st[1]), .FREQ_OK(st[2]), .PHASE_OK(st[3]),
        .ROT_OK(st[4]), .CLOSE_ENABLE(st[5]),
        .INCOHERENT_SETTING_WARNING(st[6]));

    sck_front fe (.clk(clk), .tgl(tgl), .mv(mv), .gv(gv), .mf(mf),
        .gf(gf), .ph(ph), .mr(mr), .gr(gr));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    // Verdict in one place
    task automatic close_out();
        $display("compared %0d, wrong %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // A bounded wait ran out
    task automatic stuck();
        n_fail++;
        $display("wrong value at %0t ns: wait ran out", $time);
        close_out();
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t ns: got %h, want %h", $time, got,
                exp);
        end
    endtask

    task automatic flag(input int i, input logic e);
        cmp({31'h0, st[i]}, {31'h0, e});
    endtask

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wr_en <= w;
        rd_en <= ~w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_r !== 1'b0 && n < 40);
        q = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        if (wait_r !== 1'b0)
            stuck();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        cmp(q, e);
    endtask

    // Flag must keep its value for n edges
    task automatic steady(input int i, input logic e, input int n);
        repeat (n)
        begin
            @(posedge clk);
            flag(i, e);
        end
    endtask

    task automatic rise(input int i, input int n);
        int k;
        k = 0;
        while (st[i] !== 1'b1 && k < n)
        begin
            @(posedge clk);
            k++;
        end
        if (st[i] !== 1'b1)
            stuck();
        flag(i, 1'b1);
    endtask

    task automatic hit();
        @(posedge clk);
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask

    // One set, then rotation, phase, frequency and voltage flags
    task automatic lim(input logic [23:0] a, input logic [23:0] b,
        input logic [15:0] c, input logic [15:0] d, input logic [8:0] p,
        input logic g, input logic [3:0] e);
        fe.send(a, b, c, d, p, 1'b1, g);
        cmp({28'h0, st[4:1]}, {28'h0, e});
    endtask

    // Close routing with a failing phase present
    task automatic route(input logic [31:0] c, input logic b,
        input logic w);
        hit();
        fe.send(VG, VG, FG, FG, 9'h05a, 1'b1, 1'b1);
        wr(`SCK_CTRL_OFS, c);
        repeat (4) @(posedge clk);
        flag(BRK, b);
        flag(WN, w);
    endtask

    // Common setup: no phase offset, 10 ms qualify
    task automatic setup(input logic [31:0] c);
        hit();
        wr(`SCK_DIFF_OFS, 32'h0000_0305);
        wr(`SCK_QUAL_OFS, 32'h0000_000a);
        wr(`SCK_CTRL_OFS, c);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        n_fail = 0;
        n_compared = 0;
        srst = 1'b1;
        adr = 8'h0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdat = 32'h0;
        // Reset values and an unmapped read
        hit();
        rd(`SCK_CTRL_OFS, `SCK_CTRL_RST);
        rd(`SCK_VLIM_OFS, `SCK_VLIM_RST);
        rd(`SCK_STAT_OFS, 32'h0);
        rd(8'h80, 32'h0);
        $display("test reset done");
        // Dead side, then a good set seen first: never enabled
        setup(32'h3e);
        fe.send(24'h0, 24'h0, FG, FG, 9'h0, 1'b1, 1'b1);
        lim(VG, VG, FG, FG, 9'h0, 1'b1, 4'hf);
        steady(CE, 1'b0, 60);
        $display("test dead side done");
        // Unsynchronized, qualify, enable, withdraw, hold
        setup(32'h3e);
        lim(VG, VG, FG, FG, 9'h05a, 1'b1, 4'hb);
        lim(VG, VG, FG, FG, 9'h0, 1'b1, 4'hf);
        steady(CE, 1'b0, 10);
        rise(CE, 30);
        flag(BRK, 1'b1);
        lim(VG, VG, FG, FG, 9'h05a, 1'b1, 4'hb);
        flag(CE, 1'b0);
        fe.send(VG, VG, FG, FG, 9'h0, 1'b1, 1'b1);
        steady(CE, 1'b0, 28);
        $display("test sync done");
        // Internal regulation makes its own unsynchronized step
        setup(32'h3f);
        fe.send(VG, VG, FG, FG, 9'h0, 1'b1, 1'b1);
        rise(CE, 60);
        $display("test internal done");
        // Limits and hysteresis
        setup(32'h1e);
        lim(24'h64644f, 24'h64644f, FG, FG, 9'h0, 1'b1, 4'he);
        lim(24'h5f5f5f, 24'h5f5f5f, FG, FG, 9'h0, 1'b1, 4'hf);
        lim(24'h6f6464, 24'h6f6464, FG, FG, 9'h0, 1'b1, 4'he);
        lim(VG, 24'h646a64, FG, FG, 9'h0, 1'b1, 4'he);
        lim(VG, 24'h646964, FG, FG, 9'h0, 1'b1, 4'he);
        lim(VG, 24'h646864, FG, FG, 9'h0, 1'b1, 4'hf);
        lim(VG, 24'h646964, FG, FG, 9'h0, 1'b1, 4'hf);
        lim(VG, VG, 16'h01c1, 16'h01c1, 9'h0, 1'b1, 4'hd);
        lim(VG, VG, FG, FG, 9'h0, 1'b1, 4'hf);
        lim(VG, VG, FG, 16'h01f8, 9'h0, 1'b1, 4'hd);
        lim(VG, VG, FG, 16'h01f7, 9'h0, 1'b1, 4'hd);
        lim(VG, VG, FG, 16'h01f6, 9'h0, 1'b1, 4'hf);
        lim(VG, VG, FG, FG, 9'h00b, 1'b1, 4'hb);
        lim(VG, VG, FG, FG, 9'h00a, 1'b1, 4'hb);
        lim(VG, VG, FG, FG, 9'h009, 1'b1, 4'hf);
        lim(VG, VG, FG, FG, 9'h00a, 1'b1, 4'hf);
        lim(VG, VG, FG, FG, 9'h163, 1'b1, 4'hf);
        lim(VG, VG, FG, FG, 9'h0, 1'b0, 4'h7);
        wr(`SCK_DIFF_OFS, 32'h0014_0305);
        lim(VG, VG, FG, FG, 9'h014, 1'b1, 4'hf);
        lim(VG, VG, FG, FG, 9'h0, 1'b1, 4'hb);
        wr(`SCK_DIFF_OFS, 32'h01ec_0305);
        lim(VG, VG, FG, FG, 9'h154, 1'b1, 4'hf);
        wr(`SCK_DIFF_OFS, 32'h0000_0305);
        wr(`SCK_VLIM_OFS, 32'h0014_6e50);
        rd(`SCK_VLIM_OFS, 32'h0014_6e50);
        lim(VG, VG, FG, FG, 9'h013, 1'b1, 4'hf);
        wr(`SCK_CTRL_OFS, 32'h0000_000e);
        lim(VG, 24'h645a64, FG, FG, 9'h0, 1'b1, 4'hf);
        $display("test limits done");
        // Routing of the close command and the setting warning
        route(32'h38, 1'b1, 1'b0);
        route(32'h39, 1'b0, 1'b0);
        route(32'h3c, 1'b1, 1'b0);
        route(32'h7c, 1'b0, 1'b0);
        route(32'h7a, 1'b1, 1'b0);
        route(32'h16, 1'b0, 1'b1);
        route(32'h17, 1'b0, 1'b0);
        $display("test routing done");
        close_out();
    end
endmodule
